// file: pkg/dbfs_pkg.sv
// Constants, types and register map of the dual buck fault sequencer.
// Assumes a single 25 MHz clock and APB register access.
package dbfs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 25_000_000;
	localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
	localparam int PUMP_HZ         = 260_000;
	localparam int PUMP_HALF_CYC   = CLK_HZ / (2 * PUMP_HZ);
	localparam int DEAD_NS         = 80;
	localparam int DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int OV_QUAL_NS      = 1000;
	localparam int OV_CYC          = (OV_QUAL_NS * CLK_MHZ + 999) / 1000;
	localparam int SS_MIN_US       = 2000;
	localparam int SS_CYC          = SS_MIN_US * CLK_MHZ;
	localparam int SS_STEPS        = 256;
	localparam int SS_STEP_CYC     = (SS_CYC + SS_STEPS - 1) / SS_STEPS;
	localparam int SS_MAX_ON_NS    = 1600;
	localparam int SS_MAX_ON_CYC   = SS_MAX_ON_NS * CLK_MHZ / 1000;
	localparam int BLANK_LONG_US   = 4500;
	localparam int BLANK_LONG_CYC  = BLANK_LONG_US * CLK_MHZ;
	localparam int BLANK_SHORT_US  = 1300;
	localparam int BLANK_SHORT_CYC = BLANK_SHORT_US * CLK_MHZ;
	localparam int CNT_W           = 20;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] CTRL_OFS       = 12'h000;
	localparam logic [11:0] STAT_OFS       = 12'h004;
	localparam int          CTRL_SHORT_BIT = 0;
	localparam logic        CTRL_SHORT_RST = 1'b0;
	localparam int          STAT_EN_LSB    = 0;
	localparam int          STAT_SS_LSB    = 2;
	localparam int          STAT_RUN_LSB   = 4;
	localparam int          STAT_OVF_LSB   = 6;
	localparam int          STAT_UVF_LSB   = 8;
	localparam int          STAT_HOT_BIT   = 10;
	localparam int          STAT_LOCK_BIT  = 11;
	localparam int          STAT_PG_BIT    = 12;
	localparam logic        PG_PULL_RST    = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {CH_OFF, CH_SS, CH_RUN, CH_OVF, CH_UVF} dbfs_mode_t;

	typedef struct packed {
		logic [1:0] en_on;
		logic [1:0] en_off;
		logic [1:0] ov;
		logic [1:0] uv;
		logic [1:0] pg_hi;
		logic [1:0] pg_lo;
		logic [1:0] out_hi;
		logic [1:0] pwm;
		logic       five_low;
		logic       three_low;
		logic       hot;
	} dbfs_in_t;

	typedef struct packed {
		dbfs_mode_t       mode;
		logic             en;
		logic [7:0]       ss_cnt;
		logic [7:0]       ss_ref;
		logic [CNT_W-1:0] blank;
		logic [4:0]       ov_cnt;
		logic [7:0]       on_cnt;
		logic [1:0]       dead;
		logic             hs;
		logic             ls;
		logic             dis;
	} dbfs_ch_t;

	typedef struct packed {
		dbfs_in_t        s1;
		dbfs_in_t        s2;
		dbfs_ch_t [1:0]  ch;
		logic            hot;
		logic [5:0]      pump_cnt;
		logic            pump;
		logic            pg_pull;
		logic            ctrl_short;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} dbfs_state_t;

endpackage

// file: hw/dbfs_top.sv
// Sequencer and protection logic of a two channel step-down controller.
// Assumes comparator results arrive as logic levels and APB from software.
//
// Overview of operation
// [R1] Pump clock near 260kHz runs only while first channel enable is on.
// [R2] Dead time separates high-side and low-side gate drive in both directions.
// [R3] Enabling a channel starts a reference ramp lasting at least 2ms.
// [R4] During ramp the high-side pulse width is limited.
// [R5] Both regulators low locks out switching; resumes without latch.
// [R6] Power-good pulled low during ramp, standby and shutdown.
// [R7] Power-good released only when both channels run above 88%.
// [R8] Power-good drops if a channel is off, under 80% or over 113%.
// [R9] Over-voltage fault holds the low-side drive continuously on.
// [R10] Over-voltage must persist 1us before the fault is declared.
// [R11] Over-voltage fault latches until enable toggles or power-on reset.
// [R12] Under-voltage fault forces both drives low and latches.
// [R13] Under-voltage ignored for a blanking time after channel start.
// [R14] Under-voltage latch clears only by enable toggle or reset.
// [R15] Under-voltage fault enters discharge, regulators stay on.
// [R16] Over-temperature turns everything off until power-on reset.
// [R17] Enable low or under-voltage latch closes the discharge switch.
// [R18] Discharge stays on while an output is high in standby.
// [R19] Both enables off means standby: switching off, regulators on.
// [R20] Enable uses hysteresis: off on low threshold, on on high threshold.
// [R21] Outside controller sequences the two enables independently.
// [R22] Inputs are synchronised; intervals are clock counters cleared by reset.
// [R23] Priority: thermal, then lockout, then latched faults, then ramp and run.
//
// Added by the designer: the placing of the registers and the APB slave port.
module dbfs_top #(
	parameter int BLANK_LONG_CYC  = dbfs_pkg::BLANK_LONG_CYC,
	parameter int BLANK_SHORT_CYC = dbfs_pkg::BLANK_SHORT_CYC
) (
	input  wire logic                        SYS_CLK_I,
	input  wire logic                        RST_I,
	input  wire logic                        CE_I,
	input  wire logic [1:0]                  EN_ON_I,
	input  wire logic [1:0]                  EN_OFF_I,
	input  wire logic [1:0]                  OV_TRIP_I,
	input  wire logic [1:0]                  UV_TRIP_I,
	input  wire logic [1:0]                  PG_HI_I,
	input  wire logic [1:0]                  PG_LO_I,
	input  wire logic [1:0]                  OUT_HI_I,
	input  wire logic [1:0]                  PWM_REQ_I,
	input  wire logic                        FIVE_LOW_I,
	input  wire logic                        THREE_LOW_I,
	input  wire logic                        HOT_I,
	input  wire logic                        PSEL_I,
	input  wire logic                        PENABLE_I,
	input  wire logic                        PWRITE_I,
	input  wire logic [dbfs_pkg::ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]                 PWDATA_I,
	output logic [31:0]                      PRDATA_O,
	output logic                             PREADY_O,
	output logic                             PSLVERR_O,
	output logic [1:0]                       HIGH_SIDE_GATE_O,
	output logic [1:0]                       LOW_SIDE_GATE_O,
	output logic [1:0]                       DISCH_O,
	output logic [15:0]                      SS_REF_O,
	output logic                             PUMP_CLOCK_O,
	output logic                             POWER_GOOD_O,
	output logic                             POWER_GOOD_OE_O,
	output logic                             SHUTDOWN_O
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dbfs_pkg::dbfs_state_t r;
	dbfs_pkg::dbfs_state_t n;
	dbfs_pkg::dbfs_in_t    raw;
	logic                  lock;
	logic                  standby;
	logic [dbfs_pkg::CNT_W-1:0] blank_lim;

	assign raw = '{en_on: EN_ON_I, en_off: EN_OFF_I, ov: OV_TRIP_I, uv: UV_TRIP_I,
		pg_hi: PG_HI_I, pg_lo: PG_LO_I, out_hi: OUT_HI_I, pwm: PWM_REQ_I,
		five_low: FIVE_LOW_I, three_low: THREE_LOW_I, hot: HOT_I};
	assign lock      = r.s2.five_low & r.s2.three_low; // see [R5]
	assign standby   = ~r.ch[0].en & ~r.ch[1].en; // see [R19]
	assign blank_lim = r.ctrl_short ? dbfs_pkg::CNT_W'(BLANK_SHORT_CYC - 1)
		: dbfs_pkg::CNT_W'(BLANK_LONG_CYC - 1);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		dbfs_pkg::dbfs_ch_t c;
		logic               wh;
		logic               wl;
		logic               lim;
		logic [31:0]        stat;
		c    = '0;
		wh   = 1'b0;
		wl   = 1'b0;
		lim  = 1'b0;
		stat = '0;
		n    = r;
		// Raw copy is read only by the second stage
		n.s1 = raw; // see [R22]
		n.s2 = r.s1;
		n.hot = r.hot | r.s2.hot; // see [R16]

		for (int i = 0; i < 2; i++) begin
			c = r.ch[i];
			if (c.en && r.s2.en_off[i]) begin // see [R20]
				c.en = 1'b0;
			end else if (!c.en && r.s2.en_on[i]) begin
				c.en = 1'b1;
			end
			unique case (c.mode)
				dbfs_pkg::CH_OFF: begin
					if (c.en && !lock) begin // see [R3]
						c.mode   = dbfs_pkg::CH_SS;
						c.ss_cnt = '0;
						c.ss_ref = '0;
						c.blank  = '0;
						c.ov_cnt = '0;
					end
				end
				dbfs_pkg::CH_SS, dbfs_pkg::CH_RUN: begin
					if (c.mode == dbfs_pkg::CH_SS) begin
						// One extra step after full scale keeps the ramp above 2ms
						if (c.ss_cnt == 8'(dbfs_pkg::SS_STEP_CYC - 1)) begin // see [R3]
							c.ss_cnt = '0;
							if (c.ss_ref == 8'hFF) begin
								c.mode = dbfs_pkg::CH_RUN;
							end else begin
								c.ss_ref = c.ss_ref + 8'h01;
							end
						end else begin
							c.ss_cnt = c.ss_cnt + 8'h01;
						end
					end
					if (c.blank != blank_lim) begin // see [R13]
						c.blank = c.blank + 1'b1;
					end
					if (r.s2.ov[i]) begin
						if (c.ov_cnt == 5'(dbfs_pkg::OV_CYC - 1)) begin // see [R10]
							c.mode = dbfs_pkg::CH_OVF;
						end else begin
							c.ov_cnt = c.ov_cnt + 5'h01;
						end
					end else begin
						c.ov_cnt = '0;
					end
					if (c.mode != dbfs_pkg::CH_OVF && r.s2.uv[i] && c.blank == blank_lim) begin
						c.mode = dbfs_pkg::CH_UVF; // see [R12]
					end
					// Lockout outranks faults found in the same cycle
					if (!c.en || lock) begin // see [R5] see [R23]
						c.mode = dbfs_pkg::CH_OFF;
					end
				end
				dbfs_pkg::CH_OVF, dbfs_pkg::CH_UVF: begin
					if (!c.en) begin // see [R11] see [R14]
						c.mode = dbfs_pkg::CH_OFF;
					end
				end
			endcase
			if (r.hot) begin // see [R16] see [R23]
				c.mode = dbfs_pkg::CH_OFF;
			end

			// Gate targets; thermal and lockout win over everything
			if (c.hs) begin
				c.on_cnt = (c.on_cnt == 8'hFF) ? c.on_cnt : c.on_cnt + 8'h01;
			end
			if (!r.s2.pwm[i]) begin
				c.on_cnt = '0;
			end
			lim = (c.mode == dbfs_pkg::CH_SS) &&
				(c.on_cnt >= 8'(dbfs_pkg::SS_MAX_ON_CYC)); // see [R4]
			if (!r.hot && !lock) begin
				if (c.mode == dbfs_pkg::CH_OVF) begin
					wl = 1'b1; // see [R9]
				end else if (c.mode == dbfs_pkg::CH_SS || c.mode == dbfs_pkg::CH_RUN) begin
					wh = r.s2.pwm[i] && !lim;
					wl = !wh;
				end
			end

			// A drive is dropped at once; the other waits out the dead time
			if (c.hs && !wh) begin // see [R2]
				c.hs   = 1'b0;
				c.dead = 2'(dbfs_pkg::DEAD_CYC);
			end else if (c.ls && !wl) begin
				c.ls   = 1'b0;
				c.dead = 2'(dbfs_pkg::DEAD_CYC);
			end else if (c.dead != 2'h0) begin
				c.dead = c.dead - 2'h1;
			end else if (wh && !c.ls) begin
				c.hs = 1'b1;
			end else if (wl && !c.hs) begin
				c.ls = 1'b1;
			end

			c.dis = !r.hot && (!c.en || c.mode == dbfs_pkg::CH_UVF || // see [R15] see [R17]
				(standby && |r.s2.out_hi)); // see [R18]
			n.ch[i] = c;
		end

		// Pump clock follows the first channel only
		if (r.ch[0].en && !r.hot) begin // see [R1]
			if (r.pump_cnt == 6'(dbfs_pkg::PUMP_HALF_CYC - 1)) begin
				n.pump_cnt = '0;
				n.pump     = ~r.pump;
			end else begin
				n.pump_cnt = r.pump_cnt + 6'h01;
			end
		end else begin
			n.pump_cnt = '0;
			n.pump     = 1'b0;
		end

		if (r.ch[0].mode == dbfs_pkg::CH_RUN && r.ch[1].mode == dbfs_pkg::CH_RUN &&
			!(|r.s2.pg_lo) && !(|r.s2.ov)) begin // see [R8]
			if (&r.s2.pg_hi) begin // see [R7]
				n.pg_pull = 1'b0;
			end
		end else begin
			n.pg_pull = 1'b1; // see [R6]
		end

		// Register bus: answer in the second access cycle, write on that edge
		stat[dbfs_pkg::STAT_EN_LSB +: 2] = {r.ch[1].en, r.ch[0].en};
		for (int i = 0; i < 2; i++) begin
			stat[dbfs_pkg::STAT_SS_LSB + i]  = r.ch[i].mode == dbfs_pkg::CH_SS;
			stat[dbfs_pkg::STAT_RUN_LSB + i] = r.ch[i].mode == dbfs_pkg::CH_RUN;
			stat[dbfs_pkg::STAT_OVF_LSB + i] = r.ch[i].mode == dbfs_pkg::CH_OVF;
			stat[dbfs_pkg::STAT_UVF_LSB + i] = r.ch[i].mode == dbfs_pkg::CH_UVF;
		end
		stat[dbfs_pkg::STAT_HOT_BIT]  = r.hot;
		stat[dbfs_pkg::STAT_LOCK_BIT] = lock;
		stat[dbfs_pkg::STAT_PG_BIT]   = ~r.pg_pull;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;
		n.prdata  = '0;
		if (PSEL_I && PENABLE_I && !r.pready) begin
			n.pready = 1'b1;
			if (PADDR_I == dbfs_pkg::CTRL_OFS) begin
				n.prdata[dbfs_pkg::CTRL_SHORT_BIT] = r.ctrl_short;
			end else if (PADDR_I == dbfs_pkg::STAT_OFS) begin
				n.prdata = stat;
			end else begin
				n.pslverr = 1'b1;
			end
		end
		if (PSEL_I && PENABLE_I && r.pready && PWRITE_I && PADDR_I == dbfs_pkg::CTRL_OFS) begin
			n.ctrl_short = PWDATA_I[dbfs_pkg::CTRL_SHORT_BIT];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			r            <= '0; // see [R22]
			r.pg_pull    <= dbfs_pkg::PG_PULL_RST;
			r.ctrl_short <= dbfs_pkg::CTRL_SHORT_RST;
		end else if (CE_I) begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA_O         = r.prdata;
	assign PREADY_O         = r.pready;
	assign PSLVERR_O        = r.pslverr;
	assign HIGH_SIDE_GATE_O = {r.ch[1].hs, r.ch[0].hs};
	assign LOW_SIDE_GATE_O  = {r.ch[1].ls, r.ch[0].ls};
	assign DISCH_O          = {r.ch[1].dis, r.ch[0].dis};
	assign SS_REF_O         = {r.ch[1].ss_ref, r.ch[0].ss_ref};
	assign PUMP_CLOCK_O     = r.pump;
	// Open drain: only ever pulls low
	assign POWER_GOOD_O     = 1'b0;
	assign POWER_GOOD_OE_O  = r.pg_pull;
	assign SHUTDOWN_O       = r.hot;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I || !CE_I);

	a_pump_gated: assert property ((!r.ch[0].en || r.hot) |=> !PUMP_CLOCK_O) // see [R1]
		else $error("pump clock runs without first channel enable");
	a_lock_gates: assert property (lock |=> HIGH_SIDE_GATE_O == 2'b00) // see [R5]
		else $error("high side on during lockout");
	a_pg_held: assert property ((r.ch[0].mode != dbfs_pkg::CH_RUN) |=> POWER_GOOD_OE_O) // see [R6]
		else $error("power good released while not running");
	a_pg_release: assert property ($fell(POWER_GOOD_OE_O) |-> $past(r.s2.pg_hi) == 2'b11) // see [R7]
		else $error("power good released below threshold");
	a_pg_drop: assert property ((|r.s2.pg_lo || |r.s2.ov) |=> POWER_GOOD_OE_O) // see [R8]
		else $error("power good kept despite out of range output");
	a_hot_off: assert property (r.hot |=> (HIGH_SIDE_GATE_O == 2'b00 && // see [R16]
		LOW_SIDE_GATE_O == 2'b00 && SHUTDOWN_O && DISCH_O == 2'b00))
		else $error("activity during thermal shutdown");

	for (genvar g = 0; g < 2; g++) begin : g_chk
		logic [dbfs_pkg::CNT_W-1:0] ss_len;
		logic [dbfs_pkg::CNT_W-1:0] ov_run;

		always_ff @(posedge SYS_CLK_I) begin
			if (RST_I) begin
				ss_len <= '0;
				ov_run <= '0;
			end else if (CE_I) begin
				if (r.ch[g].mode == dbfs_pkg::CH_SS) begin
					ss_len <= ss_len + 1'b1;
				end else if (r.ch[g].mode != dbfs_pkg::CH_RUN) begin
					ss_len <= '0;
				end
				ov_run <= r.s2.ov[g] ? ov_run + 1'b1 : '0;
			end
		end

		sequence s_ss_to_run;
			r.ch[g].mode == dbfs_pkg::CH_SS ##1 r.ch[g].mode == dbfs_pkg::CH_RUN;
		endsequence
		sequence s_ov_entry;
			r.ch[g].mode != dbfs_pkg::CH_OVF ##1 r.ch[g].mode == dbfs_pkg::CH_OVF;
		endsequence
		sequence s_ov_hold;
			(r.ch[g].mode == dbfs_pkg::CH_OVF && !r.hot && !lock) [*5];
		endsequence

		a_gate_excl: assert property (!(HIGH_SIDE_GATE_O[g] && LOW_SIDE_GATE_O[g])) // see [R2]
			else $error("both gate drives on");
		a_dead_hl: assert property ($fell(HIGH_SIDE_GATE_O[g]) |-> !LOW_SIDE_GATE_O[g] [*3]) // see [R2]
			else $error("low side on within dead time");
		a_dead_lh: assert property ($fell(LOW_SIDE_GATE_O[g]) |-> !HIGH_SIDE_GATE_O[g] [*3]) // see [R2]
			else $error("high side on within dead time");
		a_ss_length: assert property (s_ss_to_run |-> ss_len >= dbfs_pkg::CNT_W'(dbfs_pkg::SS_CYC)) // see [R3]
			else $error("soft start shorter than minimum");
		a_ov_qualify: assert property (s_ov_entry |-> ov_run >= dbfs_pkg::CNT_W'(dbfs_pkg::OV_CYC)) // see [R10]
			else $error("over voltage declared before qualification");
		a_ov_low_on: assert property (s_ov_hold |-> LOW_SIDE_GATE_O[g] && !HIGH_SIDE_GATE_O[g]) // see [R9]
			else $error("low side not held on in over voltage");
		a_uv_gates_off: assert property ((r.ch[g].mode == dbfs_pkg::CH_UVF) |=> // see [R12]
			!HIGH_SIDE_GATE_O[g] && !LOW_SIDE_GATE_O[g])
			else $error("gate drive on in under voltage fault");
		a_disch_on: assert property ((!r.hot && !r.ch[g].en) ##1 !r.ch[g].en |-> DISCH_O[g]) // see [R17]
			else $error("discharge open while channel disabled");
	end

endmodule

// file: testbench/dbfs_plant.sv
// Plant model: enable divider, power stage output and its comparators.
// Assumes the sequencer clock plus its discharge and ramp reference outputs.
module dbfs_plant (
	input  wire logic             clk_i,
	input  wire logic [1:0][11:0] en_mv_i,
	input  wire logic [1:0]       ov_force_i,
	input  wire logic [1:0]       uv_force_i,
	input  wire logic [1:0]       sag_i,
	input  wire logic [1:0]       disch_i,
	input  wire logic [15:0]      ss_ref_i,
	output logic [1:0]            en_on_o,
	output logic [1:0]            en_off_o,
	output logic [1:0]            ov_o,
	output logic [1:0]            uv_o,
	output logic [1:0]            pg_hi_o,
	output logic [1:0]            pg_lo_o,
	output logic [1:0]            out_hi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int v [2] = '{0, 0};
	int t;
	// Output in percent follows the ramp; discharge drains it one step a cycle
	always @(posedge clk_i) begin
		for (int i = 0; i < 2; i++) begin
			t = disch_i[i] ? 0 : int'(ss_ref_i[i*8 +: 8]) * 100 / 255;
			v[i] <= v[i] + int'(t > v[i]) - int'(t < v[i]);
		end
	end
	// Undervoltage only on command: a short blanking would trip on the ramp
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			en_on_o[i]  = en_mv_i[i] > 12'h640;
			en_off_o[i] = en_mv_i[i] < 12'h190;
			ov_o[i]     = ov_force_i[i] || v[i] > 113;
			uv_o[i]     = uv_force_i[i];
			pg_hi_o[i]  = v[i] > 88;
			pg_lo_o[i]  = sag_i[i] || v[i] < 80;
			out_hi_o[i] = v[i] > 5;
		end
	end
endmodule

// file: testbench/dbfs_top_test.sv
// Self-checking bench for the dual buck fault sequencer.
// Assumes the plant model feeds enables and comparators; APB from tasks.
module dbfs_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic [1:0][11:0] en_mv = '0;
	logic [1:0]       ovf = '0, uvf = '0, sag = '0, pwm = '0, pwm_fix = '0;
	logic             five = 1'b0, three = 1'b0, hot = 1'b0, rnd_on = 1'b1;
	logic             psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, pready, pslverr;
	logic [11:0]      paddr = '0;
	logic [31:0]      pwdata = '0, rd, rv, prdata, seed = 32'h2856BC36;
	logic             pump, pg, pg_oe, sd, pg_wire;
	logic [1:0]       hs, ls, dis, en_on, en_off, ov, uv, pghi, pglo, outhi, h1, h2, l1, l2;
	logic [15:0]      ss_ref;
	int               failures = 0, tests_run = 0, cyc = 0, t0, n, hi, lo, mx;

	// Open-drain line with its pull-up
	assign pg_wire = pg_oe ? pg : 1'b1;

	dbfs_top #(.BLANK_LONG_CYC(300), .BLANK_SHORT_CYC(100)) u_dut (
		.SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .EN_ON_I(en_on), .EN_OFF_I(en_off),
		.OV_TRIP_I(ov), .UV_TRIP_I(uv), .PG_HI_I(pghi), .PG_LO_I(pglo), .OUT_HI_I(outhi),
		.PWM_REQ_I(pwm), .FIVE_LOW_I(five), .THREE_LOW_I(three), .HOT_I(hot),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .HIGH_SIDE_GATE_O(hs),
		.LOW_SIDE_GATE_O(ls), .DISCH_O(dis), .SS_REF_O(ss_ref), .PUMP_CLOCK_O(pump),
		.POWER_GOOD_O(pg), .POWER_GOOD_OE_O(pg_oe), .SHUTDOWN_O(sd));
	dbfs_plant u_plant (.clk_i(clk), .en_mv_i(en_mv), .ov_force_i(ovf), .uv_force_i(uvf),
		.sag_i(sag), .disch_i(dis), .ss_ref_i(ss_ref), .en_on_o(en_on), .en_off_o(en_off),
		.ov_o(ov), .uv_o(uv), .pg_hi_o(pghi), .pg_lo_o(pglo), .out_hi_o(outhi));

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task wn(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Request held until ready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		// Ready and data are sampled at the rising edge, as they stood before it
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk(k < 20, "no bus answer");
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task st();
		apb(1'b0, dbfs_pkg::STAT_OFS, 32'h0);
	endtask
	task runlen(input logic lvl, output int k);
		k = 0;
		while (pump === lvl && k < 200) begin
			@(negedge clk);
			k++;
		end
	endtask

	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		rv = xs();
		pwm <= rnd_on ? rv[1:0] : pwm_fix;
		cyc <= cyc + 1;
	end
	// Gate overlap and dead time watched on every cycle
	always @(negedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!rst && hs[i] === 1'b1 && ls[i] === 1'b1) chk(1'b0, "gates overlap");
			if (!rst && ls[i] === 1'b1 && l1[i] === 1'b0) chk(!(h1[i] | h2[i]), "dead lo");
			if (!rst && hs[i] === 1'b1 && h1[i] === 1'b0) chk(!(l1[i] | l2[i]), "dead hi");
		end
		h2 <= h1;
		h1 <= hs;
		l2 <= l1;
		l1 <= ls;
	end
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		$display("ERROR %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wn(5);
		chk(hs === 2'h0 && ls === 2'h0 && pump === 1'b0 && sd === 1'b0, "reset");
		chk(dis === 2'h3 && pg_wire === 1'b0, "standby");
		st();
		chk(rd === 32'h0 && e === 1'b0, "idle status");
		apb(1'b0, 12'h008, 32'h0);
		chk(rd === 32'h0 && e === 1'b1, "unmapped");
		apb(1'b1, dbfs_pkg::STAT_OFS, 32'hFFFF_FFFF);
		st();
		chk(rd === 32'h0 && e === 1'b0, "status read only");
		apb(1'b0, dbfs_pkg::CTRL_OFS, 32'h0);
		chk(rd === 32'h0, "control reset");
		apb(1'b1, dbfs_pkg::CTRL_OFS, 32'h1);
		apb(1'b0, dbfs_pkg::CTRL_OFS, 32'h0);
		chk(rd === 32'h1, "short blanking");
		@(posedge clk);
		en_mv[0] <= 12'h3E8;
		wn(20);
		chk(pump === 1'b0 && dis[0] === 1'b1, "band keeps off");
		@(posedge clk);
		en_mv <= {12'h7D0, 12'h000};
		uvf[1] <= 1'b1;
		wn(80);
		st();
		chk(rd[9] === 1'b0 && dis[1] === 1'b0 && pump === 1'b0, "blanked");
		wn(40);
		st();
		chk(rd[9] === 1'b1 && dis[1] === 1'b1 && hs[1] === 1'b0 && ls[1] === 1'b0, "uv");
		@(posedge clk);
		uvf[1] <= 1'b0;
		wn(20);
		st();
		chk(rd[9] === 1'b1, "uv held");
		@(posedge clk);
		en_mv <= '0;
		wn(10);
		@(posedge clk);
		en_mv <= {12'h7D0, 12'h7D0};
		t0 = cyc;
		wn(10);
		st();
		chk(rd[9:8] === 2'h0 && dis === 2'h0, "toggle clears");
		runlen(1'b1, n);
		runlen(1'b0, n);
		runlen(1'b1, hi);
		runlen(1'b0, lo);
		chk(hi == dbfs_pkg::PUMP_HALF_CYC && lo == dbfs_pkg::PUMP_HALF_CYC, "pump");
		@(posedge clk);
		en_mv[0] <= 12'h3E8;
		rnd_on <= 1'b0;
		pwm_fix <= 2'h1;
		mx = 0;
		n = 0;
		repeat (150) begin
			@(negedge clk);
			n = hs[0] === 1'b1 ? n + 1 : 0;
			mx = n > mx ? n : mx;
		end
		chk(dis[0] === 1'b0 && pg_wire === 1'b0, "band keeps on");
		chk(mx > 0 && mx <= dbfs_pkg::SS_MAX_ON_CYC, "ramp on-time");
		@(posedge clk);
		en_mv[0] <= 12'h7D0;
		rnd_on <= 1'b1;
		while (cyc < t0 + 2000) wn(1);
		chk(ss_ref[7:0] >= 8'h08 && ss_ref[7:0] <= 8'h0C, "ramp slope");
		while (cyc < t0 + dbfs_pkg::SS_CYC - 1200) wn(1);
		st();
		chk(rd[5:4] === 2'h0, "still ramping");
		n = 0;
		do begin
			wn(100);
			st();
			n++;
		end while (rd[5:4] !== 2'h3 && n < 40);
		chk(rd[5:4] === 2'h3 && cyc - t0 >= dbfs_pkg::SS_CYC, "ramp length");
		wn(150);
		st();
		chk(rd[12] === 1'b1 && pg_wire === 1'b1, "pg released");
		@(posedge clk);
		sag[1] <= 1'b1;
		wn(8);
		chk(pg_wire === 1'b0, "sag");
		@(posedge clk);
		sag[1] <= 1'b0;
		// Glitches up to one cycle short of qualification, longest first
		for (int j = 0; j < 6; j++) begin
			n = j == 0 ? 24 : 1 + xs() % 24;
			@(posedge clk);
			ovf[0] <= 1'b1;
			repeat (n) @(posedge clk);
			ovf[0] <= 1'b0;
			wn(5);
		end
		st();
		chk(rd[7:6] === 2'h0 && pg_wire === 1'b1, "ov filtered");
		@(posedge clk);
		ovf[0] <= 1'b1;
		wn(40);
		n = 0;
		repeat (50) begin
			@(negedge clk);
			n += ls[0] === 1'b1 && hs[0] === 1'b0;
		end
		chk(n == 50 && pg_wire === 1'b0, "ov clamp");
		@(posedge clk);
		ovf[0] <= 1'b0;
		wn(20);
		st();
		chk(rd[7:6] === 2'h1 && ls[0] === 1'b1, "ov latched");
		@(posedge clk);
		five <= 1'b1;
		wn(10);
		st();
		chk(rd[11] === 1'b0, "one rail low");
		@(posedge clk);
		three <= 1'b1;
		wn(10);
		st();
		chk(rd[11] === 1'b1 && hs === 2'h0 && ls === 2'h0, "lockout");
		@(posedge clk);
		five <= 1'b0;
		three <= 1'b0;
		n = 0;
		repeat (100) begin
			@(negedge clk);
			n += hs[1] === 1'b1;
		end
		st();
		chk(n > 0 && rd[11] === 1'b0 && rd[6] === 1'b1 && ls[0] === 1'b1, "resume");
		@(posedge clk);
		en_mv[0] <= 12'h000;
		wn(10);
		st();
		chk(rd[6] === 1'b0 && ls[0] === 1'b0 && dis[0] === 1'b1, "enable off");
		chk(pump === 1'b0 && pg_wire === 1'b0, "off stops pump, pg");
		@(posedge clk);
		en_mv[0] <= 12'h7D0;
		hot <= 1'b1;
		wn(5);
		@(posedge clk);
		hot <= 1'b0;
		n = 0;
		repeat (50) begin
			@(negedge clk);
			n += sd === 1'b1 && hs === 2'h0 && ls === 2'h0 && pump === 1'b0;
		end
		chk(n == 50, "thermal holds");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wn(3);
		chk(sd === 1'b0, "reset ends thermal");
		tally_and_finish();
	end
endmodule
